//--- shared/wfc_pkg.sv
// wake frame filter configuration: constants, register map and field layout
// assumes a 7-bit byte register port and one 125 MHz clock
package wfc_pkg;

	localparam int WFC_ADDR_W = 7;
	localparam int WFC_DATA_W = 8;
	localparam int WFC_NREG   = 10;

	// register offsets
	localparam logic [6:0] WFC_OFS_CONTROL         = 7'h20;
	localparam logic [6:0] WFC_OFS_IDENT_MID_HIGH  = 7'h24;
	localparam logic [6:0] WFC_OFS_IDENT_MID_LOW   = 7'h25;
	localparam logic [6:0] WFC_OFS_IDENT_LOW_FLAGS = 7'h26;
	localparam logic [6:0] WFC_OFS_MASK_TOP        = 7'h27;
	localparam logic [6:0] WFC_OFS_MASK_MID_HIGH   = 7'h28;
	localparam logic [6:0] WFC_OFS_MASK_MID_LOW    = 7'h29;
	localparam logic [6:0] WFC_OFS_MASK_LOW        = 7'h2a;
	localparam logic [6:0] WFC_OFS_LENGTH_CODE     = 7'h2b;
	localparam logic [6:0] WFC_OFS_PAYLOAD_BYTE7   = 7'h2c;
	localparam logic [6:0] WFC_OFS_PAYLOAD_BYTE6   = 7'h2d;

	// index of each bank register
	localparam int WFC_IX_IDENT_MID_HIGH  = 0;
	localparam int WFC_IX_IDENT_MID_LOW   = 1;
	localparam int WFC_IX_IDENT_LOW_FLAGS = 2;
	localparam int WFC_IX_MASK_TOP        = 3;
	localparam int WFC_IX_MASK_MID_HIGH   = 4;
	localparam int WFC_IX_MASK_MID_LOW    = 5;
	localparam int WFC_IX_MASK_LOW        = 6;
	localparam int WFC_IX_LENGTH_CODE     = 7;
	localparam int WFC_IX_PAYLOAD_BYTE7   = 8;
	localparam int WFC_IX_PAYLOAD_BYTE6   = 9;

	// tables, highest index first
	localparam logic [WFC_NREG-1:0][6:0] WFC_REG_OFS = {
		WFC_OFS_PAYLOAD_BYTE6, WFC_OFS_PAYLOAD_BYTE7, WFC_OFS_LENGTH_CODE,
		WFC_OFS_MASK_LOW, WFC_OFS_MASK_MID_LOW, WFC_OFS_MASK_MID_HIGH,
		WFC_OFS_MASK_TOP, WFC_OFS_IDENT_LOW_FLAGS, WFC_OFS_IDENT_MID_LOW,
		WFC_OFS_IDENT_MID_HIGH};
	localparam logic [WFC_NREG-1:0][7:0] WFC_REG_WMASK = {
		8'hff, 8'hff, 8'h0f, 8'h7c, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};
	localparam logic [WFC_NREG-1:0][7:0] WFC_REG_KEEP = {
		8'hff, 8'hff, 8'h0f, 8'h7c, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};
	localparam logic [WFC_NREG-1:0][7:0] WFC_REG_RESET = '0;
	localparam logic [7:0] WFC_CONTROL_RESET = 8'h00;

	// field positions
	localparam int WFC_IDL_IDENT_MSB = 6;
	localparam int WFC_IDL_IDENT_LSB = 2;
	localparam int WFC_IDL_RTR_BIT   = 1;
	localparam int WFC_IDL_IDE_BIT   = 0;
	localparam int WFC_MSKL_MSB      = 6;
	localparam int WFC_MSKL_LSB      = 2;
	localparam int WFC_LEN_MSB       = 3;
	localparam int WFC_CTL_VALID_BIT = 0;

	// length code decode
	localparam logic [3:0] WFC_LEN_PLAIN_MAX = 4'h7;
	localparam logic [3:0] WFC_LEN_FULL      = 4'h8;

endpackage

//--- shared/wfc_wr_if.sv
// wake frame filter configuration: write path shared by the bank registers
// assumes the top drives every signal from the register port and reset inputs
interface wfc_wr_if;
	logic [7:0] wdata;
	logic       soft_clr;
	logic       restart;

	modport drv
	(
		output wdata,
		output soft_clr,
		output restart
	);
	modport rcv
	(
		input  wdata,
		input  soft_clr,
		input  restart
	);
endinterface

//--- hdl/wfc_byte_reg.sv
// wake frame filter configuration: one byte register with write and keep masks
// assumes wr_sel is a one-cycle strobe on the same clock
module wfc_byte_reg
	import wfc_pkg::*;
#(
	parameter logic [7:0] WMASK = 8'hff,
	parameter logic [7:0] KEEP  = 8'hff,
	parameter logic [7:0] RESET = 8'h00
)
(
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       wr_sel,
	wfc_wr_if.rcv           bus,
	output      logic [7:0] q,
	output      logic       changed
);

	logic [7:0] q_q;
	logic [7:0] q_d;
	logic [7:0] wr_val;

	// reserved bits are masked off so they never hold a one
	assign wr_val  = bus.wdata & WMASK;
	assign q_d     = bus.soft_clr ? RESET :
	                 bus.restart  ? (q_q & KEEP) :
	                 wr_sel       ? wr_val : q_q;
	assign changed = wr_sel & (wr_val != q_q);
	assign q       = q_q;

	always_ff @(posedge clock)
	begin
		if (srst)
			q_q <= RESET;
		else
			q_q <= q_d;
	end

endmodule // wfc_byte_reg

//--- hdl/wfc_len_decode.sv
// wake frame filter configuration: length code to data field byte count
// assumes a stored 4-bit code at its input
module wfc_len_decode
	import wfc_pkg::*;
(
	input  wire logic [3:0] code,
	output      logic [3:0] bytes
);

	logic over_plain;

	assign over_plain = code > WFC_LEN_PLAIN_MAX;
	assign bytes      = over_plain ? WFC_LEN_FULL : code;

endmodule // wfc_len_decode

//--- hdl/wfc_top.sv
// wake frame filter configuration bank with its register port
// assumes soft_reset, restart, wake_event and the port come from logic on clock
//
// Operation
// R1 - identifier bits 20..13 in one rw byte
// R2 - identifier bits 12..5 in one rw byte
// R3 - identifier bits 4..0 at 6:2, bit7 reserved
// R4 - bit1 selects data frame or remote request
// R5 - software keeps remote request flag at zero
// R6 - bit0 selects 11-bit or 29-bit identifier
// R7 - mask one compares bit, zero ignores it
// R8 - three full mask bytes at consecutive addresses
// R9 - low mask bits 4..0 at 6:2, others reserved
// R10 - reserved bits ignore writes, read zero
// R11 - length code is rw bits 3:0
// R12 - codes above seven mean eight bytes
// R13 - payload bytes seven and six, full rw
// R14 - reset clears every bank register
// R15 - restart clears reserved bits, keeps the rest
// R16 - valid flag clears on change, wake, reset
// R17 - standard identifier sits in bits 28..18
// R18 - configuration drives stable parallel outputs
module wfc_top
	import wfc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        soft_reset,
	input  wire logic        restart,
	input  wire logic        wake_event,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output      logic [7:0]  reg_rdata,
	output      logic        config_valid_flag,
	output      logic [7:0]  ident_bits_mid_high,
	output      logic [7:0]  ident_bits_mid_low,
	output      logic [4:0]  ident_bits_low,
	output      logic        remote_request,
	output      logic        ident_extended,
	output      logic        remote_request_misuse,
	output      logic [7:0]  compare_mask_top,
	output      logic [7:0]  compare_mask_mid_high,
	output      logic [7:0]  compare_mask_mid_low,
	output      logic [4:0]  compare_mask_low,
	output      logic [28:0] compare_mask_full,
	output      logic [10:0] compare_mask_std,
	output      logic [3:0]  length_code,
	output      logic [3:0]  payload_length,
	output      logic [7:0]  payload_byte_seven,
	output      logic [7:0]  payload_byte_six
);

	wfc_wr_if wr_bus();

	logic [WFC_NREG-1:0][7:0] reg_q;
	logic [WFC_NREG-1:0]      wr_sel;
	logic [WFC_NREG-1:0]      reg_changed;
	logic                     ctl_wr;
	logic                     cfg_changed;
	logic                     valid_clr;
	logic                     valid_q;
	logic                     valid_d;
	logic [7:0]               control_val;
	logic [7:0]               rd_val;
	logic [7:0]               rdata_q;
	logic [7:0]               rdata_d;
	logic [7:0]               ident_low_flags;
	logic [7:0]               mask_low_reg;
	logic [7:0]               length_reg;

	// address decode, shared by write select and read lookup
	function automatic logic addr_hit
	(
		input logic [6:0] addr,
		input int         ix
	);
		addr_hit = (addr == WFC_REG_OFS[ix]);
	endfunction

	function automatic logic [7:0] rd_lookup
	(
		input logic [6:0]               addr,
		input logic [WFC_NREG-1:0][7:0] regs,
		input logic [7:0]               ctl
	);
		logic [7:0] v;
		v = 8'h00;
		if (addr == WFC_OFS_CONTROL)
			v = ctl;
		for (int i = 0; i < WFC_NREG; i++)
		begin
			if (addr_hit(addr, i))
				v = regs[i];
		end
		rd_lookup = v;
	endfunction

	// write path into the bank
	assign wr_bus.wdata    = reg_wdata;
	assign wr_bus.soft_clr = soft_reset; // [R14]
	assign wr_bus.restart  = restart; // [R15]

	genvar gi;
	generate
		for (gi = 0; gi < WFC_NREG; gi++)
		begin : g_bank
			assign wr_sel[gi] = reg_wr & addr_hit(reg_addr, gi);

			// write masks drop reserved bits, keep masks clear them on restart
			wfc_byte_reg #(
				.WMASK (WFC_REG_WMASK[gi]), // [R10]
				.KEEP  (WFC_REG_KEEP[gi]),  // [R15]
				.RESET (WFC_REG_RESET[gi])  // [R14]
			) u_reg (
				.clock   (clock),
				.srst    (srst), // [R14]
				.wr_sel  (wr_sel[gi]), // [R1] [R2] [R8] [R13]
				.bus     (wr_bus.rcv),
				.q       (reg_q[gi]),
				.changed (reg_changed[gi])
			);
		end
	endgenerate

	// configuration valid flag
	// a rewrite with the same value leaves the flag set, so software can
	// refresh the bank without losing validation
	assign ctl_wr      = reg_wr & (reg_addr == WFC_OFS_CONTROL);
	assign cfg_changed = |reg_changed; // [R16]
	assign valid_clr   = cfg_changed | wake_event | soft_reset | restart; // [R16]
	// the clear wins over a set in the same cycle: a wake must not leave
	// a stale configuration marked valid
	assign valid_d     = valid_clr ? 1'b0 :
	                     ctl_wr    ? reg_wdata[WFC_CTL_VALID_BIT] : valid_q;

	always_ff @(posedge clock)
	begin
		if (srst)
			valid_q <= WFC_CONTROL_RESET[WFC_CTL_VALID_BIT]; // [R16]
		else
			valid_q <= valid_d;
	end

	assign control_val = {7'h00, valid_q};

	// read path, data stand only in the cycle after the strobe
	assign rd_val  = rd_lookup(reg_addr, reg_q, control_val); // [R10]
	assign rdata_d = reg_rd ? rd_val : 8'h00;

	always_ff @(posedge clock)
	begin
		if (srst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// field breakout towards the frame comparator
	assign ident_low_flags = reg_q[WFC_IX_IDENT_LOW_FLAGS];
	assign mask_low_reg    = reg_q[WFC_IX_MASK_LOW];
	assign length_reg      = reg_q[WFC_IX_LENGTH_CODE];

	assign config_valid_flag   = valid_q;
	assign ident_bits_mid_high = reg_q[WFC_IX_IDENT_MID_HIGH]; // [R1] [R18]
	assign ident_bits_mid_low  = reg_q[WFC_IX_IDENT_MID_LOW]; // [R2] [R18]
	assign ident_bits_low      = ident_low_flags[WFC_IDL_IDENT_MSB:WFC_IDL_IDENT_LSB]; // [R3]
	assign remote_request      = ident_low_flags[WFC_IDL_RTR_BIT]; // [R4]
	assign ident_extended      = ident_low_flags[WFC_IDL_IDE_BIT]; // [R6]

	// flags a configuration that no wake frame can ever match
	assign remote_request_misuse = remote_request; // [R5]

	assign compare_mask_top      = reg_q[WFC_IX_MASK_TOP]; // [R8]
	assign compare_mask_mid_high = reg_q[WFC_IX_MASK_MID_HIGH]; // [R8]
	assign compare_mask_mid_low  = reg_q[WFC_IX_MASK_MID_LOW]; // [R8]
	assign compare_mask_low      = mask_low_reg[WFC_MSKL_MSB:WFC_MSKL_LSB]; // [R9]

	// a one in the full mask means the comparator checks that bit
	assign compare_mask_full = {compare_mask_top, compare_mask_mid_high,
	                            compare_mask_mid_low, compare_mask_low}; // [R7]

	// standard identifiers use the top eleven positions, not the low ones
	assign compare_mask_std = compare_mask_full[28:18]; // [R17]

	assign length_code = length_reg[WFC_LEN_MSB:0]; // [R11]

	wfc_len_decode u_len
	(
		.code  (length_code),
		.bytes (payload_length) // [R12]
	);

	assign payload_byte_seven = reg_q[WFC_IX_PAYLOAD_BYTE7]; // [R13] [R18]
	assign payload_byte_six   = reg_q[WFC_IX_PAYLOAD_BYTE6]; // [R13] [R18]

endmodule // wfc_top

//--- tb/wfc_top_sva.sv
// checker for the wake frame configuration bank: register port and config outputs
// assumes it is bound into wfc_top and sees only that module's ports
module wfc_top_sva
(
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       soft_reset,
	input wire logic       restart,
	input wire logic       wake_event,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       config_valid_flag,
	input wire logic [7:0] ident_bits_mid_high,
	input wire logic       remote_request,
	input wire logic       ident_extended,
	input wire logic [4:0] compare_mask_low,
	input wire logic [3:0] length_code,
	input wire logic [3:0] payload_length
);
	timeunit 1ns;
	timeprecision 1ps;
	// a write only lands when neither clear source overrides it
	wire wr_ok = reg_wr && !soft_reset && !restart;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	property p_id_high;
		wr_ok && reg_addr == 7'h24 |=> ident_bits_mid_high == $past(reg_wdata);
	endproperty
	a_id_high: assert property (p_id_high) else $error("ident high byte not taken");
	property p_flags;
		wr_ok && reg_addr == 7'h26 |=> {remote_request, ident_extended} == $past(reg_wdata[1:0]);
	endproperty
	a_flags: assert property (p_flags) else $error("frame type flags not taken");
	property p_mask_low;
		wr_ok && reg_addr == 7'h2a |=> compare_mask_low == $past(reg_wdata[6:2]);
	endproperty
	a_mask_low: assert property (p_mask_low) else $error("low mask field wrong");
	property p_len;
		wr_ok && reg_addr == 7'h2b |=> length_code == $past(reg_wdata[3:0]);
	endproperty
	a_len: assert property (p_len) else $error("length code not taken");
	property p_paylen;
		payload_length == ((length_code > 4'h7) ? 4'h8 : length_code);
	endproperty
	a_paylen: assert property (p_paylen) else $error("payload length decode wrong");
	property p_rd_res;
		reg_rd && reg_addr == 7'h2a |=> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0;
	endproperty
	a_rd_res: assert property (p_rd_res) else $error("reserved mask bits read nonzero");
	property p_soft;
		soft_reset |=> ident_bits_mid_high == 8'h00 && length_code == 4'h0 && !config_valid_flag;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset left state");
	property p_restart;
		restart && !soft_reset |=> $stable(length_code) && !config_valid_flag;
	endproperty
	a_restart: assert property (p_restart) else $error("restart lost length code");
	property p_wake;
		wake_event |=> !config_valid_flag ##1 $stable(ident_bits_mid_high) || $past(reg_wr);
	endproperty
	a_wake: assert property (p_wake) else $error("wake left valid flag set");
	c_soft: cover property (soft_reset);
	c_restart: cover property (restart);
	c_rd_res: cover property (reg_rd && reg_addr == 7'h2a);
endmodule // wfc_top_sva

bind wfc_top wfc_top_sva u_sva (.clock, .srst, .soft_reset, .restart, .wake_event,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .config_valid_flag,
	.ident_bits_mid_high, .remote_request, .ident_extended, .compare_mask_low,
	.length_code, .payload_length);

//--- tb/tb.sv
// testbench for the wake frame configuration bank
// assumes wfc_top on one 125 MHz clock with the checker bound beside it
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, srst = 1, soft_reset = 0, restart = 0, wake_event = 0;
	logic reg_wr = 0, reg_rd = 0, rd_p = 0, config_valid_flag, remote_request;
	logic remote_request_misuse, ident_extended;
	logic [7:0] ident_bits_mid_low, compare_mask_top, compare_mask_mid_high, compare_mask_mid_low;
	logic [7:0] payload_byte_seven, payload_byte_six;
	logic [4:0] ident_bits_low, compare_mask_low;
	logic [3:0] length_code;
	logic [6:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, ident_bits_mid_high, m [128];
	logic [28:0] compare_mask_full;
	logic [10:0] compare_mask_std;
	logic [3:0] payload_length;
	logic [31:0] s = 44;
	logic [7:0] q [$];
	int fail_count = 0, samples_checked = 0, cyc = 0;
	always #4 clock = ~clock;
	wfc_top u_dut (.clock, .srst, .soft_reset, .restart, .wake_event, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .config_valid_flag, .ident_bits_mid_high,
		.ident_bits_mid_low, .ident_bits_low, .remote_request, .ident_extended,
		.remote_request_misuse, .compare_mask_top, .compare_mask_mid_high,
		.compare_mask_mid_low, .compare_mask_low, .compare_mask_full, .compare_mask_std,
		.length_code, .payload_length, .payload_byte_seven, .payload_byte_six);
	// writable bits per address; restart keeps these in the bank
	function automatic logic [7:0] wm(logic [6:0] a);
		case (a)
			7'h20: return 8'h01;
			7'h24, 7'h25, 7'h27, 7'h28, 7'h29, 7'h2c, 7'h2d: return 8'hff;
			7'h26: return 8'h7f;
			7'h2a: return 8'h7c;
			7'h2b: return 8'h0f;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s[7:0];
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (e !== g)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [6:0] a, logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		m[a] = d & wm(a);
		@(negedge clock);
	endtask
	task automatic rd(logic [6:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q.push_back(m[a]);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task automatic pulse(logic [2:0] v);
		@(posedge clock);
		{soft_reset, restart, wake_event} <= v;
		@(posedge clock);
		{soft_reset, restart, wake_event} <= 3'b000;
		@(negedge clock);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge clock) rd_p <= reg_rd;
	always @(negedge clock)
	begin
		if (rd_p)
			chk("rdata", q.pop_front(), reg_rdata);
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			summarize();
		end
	end
	initial
	begin
		foreach (m[i]) m[i] = 8'h00;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		for (int a = 7'h20; a <= 7'h2e; a++) rd(7'(a));
		$display("test reset values done");
		for (int a = 7'h24; a <= 7'h2d; a++)
		begin
			wr(7'(a), (a == 7'h26) ? (xs() & 8'hfd) : xs());
			rd(7'(a));
		end
		@(negedge clock);
		chk("mask_full", {m[39], m[40], m[41], m[42][6:2]}, compare_mask_full);
		chk("mask_std", {m[39], m[40][7:5]}, compare_mask_std);
		chk("flags", m[38][1:0], {remote_request, ident_extended});
		chk("misuse", m[38][1], remote_request_misuse);
		chk("id_high", m[36], ident_bits_mid_high);
		chk("id_mid_low", m[37], ident_bits_mid_low);
		chk("id_low", m[38][6:2], ident_bits_low);
		chk("mask_bytes", {m[39], m[40], m[41]},
			{compare_mask_top, compare_mask_mid_high, compare_mask_mid_low});
		chk("mask_low", m[42][6:2], compare_mask_low);
		chk("len", m[43][3:0], length_code);
		chk("pay7", m[44], payload_byte_seven);
		chk("pay6", m[45], payload_byte_six);
		wr(7'h26, m[38] | 8'h02);
		chk("misuse_set", 1, remote_request_misuse);
		wr(7'h26, m[38] & 8'hfd);
		$display("test random config done");
		for (int c = 0; c < 16; c++)
		begin
			wr(7'h2b, 8'hf0 | 8'(c));
			chk("paylen", (c > 7) ? 8 : c, payload_length);
		end
		for (int a = 7'h24; a <= 7'h2d; a++) wr(7'(a), (a == 7'h26) ? 8'hfd : 8'hff);
		pulse(3'b010);
		for (int a = 7'h24; a <= 7'h2d; a++) rd(7'(a));
		$display("test reserved and restart done");
		wr(7'h20, 8'h01);
		chk("valid_set", 1, config_valid_flag);
		wr(7'h24, m[36]);
		chk("valid_same", 1, config_valid_flag);
		wr(7'h24, ~m[36]);
		chk("valid_chg", 0, config_valid_flag);
		wr(7'h20, 8'h01);
		rd(7'h20);
		pulse(3'b001);
		chk("valid_wake", 0, config_valid_flag);
		wr(7'h20, 8'h01);
		pulse(3'b100);
		foreach (m[i]) m[i] = 8'h00;
		chk("valid_soft", 0, config_valid_flag);
		for (int a = 7'h24; a <= 7'h2d; a++) rd(7'(a));
		repeat (2) @(negedge clock);
		$display("test valid flag and soft reset done");
		summarize();
	end
endmodule // tb
